// ### verilog/gpfc_regs.vh
// Register offsets, field positions and reset values of the pin function block.
// Assumes a 12-bit APB byte address and one aligned 32-bit word per register.
//
// Summary of operation
// - After any reset every pin is an input and stays one until software changes its setup.
// - Each direction bit is read/write, 1 selects output, 0 selects input, and it resets to 0; the copy in a function select register ignores writes.
// - Reading an output latch bit returns the latch contents, never the pin level.
// - The input level bits are read-only and return the level sensed on each pin.
// - The peripheral mode bit resets to 0 for GPIO, and at 1 the pin carries the chosen function.
// - The pull-up enable bit turns the pull-up on at 1, off at 0, and resets to 0.
// - The pull-up is forced off while the pin is a GPIO output, peripheral output or bus pin.
// - The open-drain bit selects an NMOS open-drain driver at 1 and push-pull at 0.
// - The drive field resets to low drive, 01 and 10 select middle drive, 11 is invalid.
// - Every pin owns a function select register with function, IRQ and analog select fields.
// - Function select registers are write protected from reset until the guard enables them.
// - One function may be assigned to several pins without hindrance, and software avoids it.
// - A pin may feed its IRQ line and its peripheral function at the same time.

`ifndef GPFC_REGS_VH
`define GPFC_REGS_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define GPFC_OFF_PORT_CTRL_ONE 12'h000
`define GPFC_OFF_PORT_CTRL_TWO 12'h004
`define GPFC_OFF_WRITE_GUARD 12'h008
`define GPFC_OFF_PFS_BASE 12'h040
`define GPFC_OFF_PFS_LAST 12'h07c

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define GPFC_P1_DIR_LSB 0
`define GPFC_P1_LATCH_LSB 16
`define GPFC_GUARD_EN_BIT 0
`define GPFC_PFS_LATCH_BIT 0
`define GPFC_PFS_LEVEL_BIT 1
`define GPFC_PFS_DIR_BIT 2
`define GPFC_PFS_PULLUP_BIT 4
`define GPFC_PFS_OD_BIT 6
`define GPFC_PFS_DRV_LSB 10
`define GPFC_PFS_DRV_MSB 11
`define GPFC_PFS_IRQ_INPUT_SELECT_BIT 14
`define GPFC_PFS_ANALOG_INPUT_SELECT_BIT 15
`define GPFC_PFS_PMR_BIT 16
`define GPFC_PFS_FSEL_LSB 24
`define GPFC_PFS_FSEL_MSB 28

// ----------------------------------------------------------------------------
// Reset values and encodings
// ----------------------------------------------------------------------------
`define GPFC_RST_PORT_CTRL_ONE 32'h00000000
`define GPFC_RST_GUARD 1'b0
`define GPFC_RST_PULLUP 1'b0
`define GPFC_RST_OD 1'b0
`define GPFC_RST_DRV 2'h0
`define GPFC_RST_IRQ_INPUT_SELECT 1'b0
`define GPFC_RST_ANALOG_INPUT_SELECT 1'b0
`define GPFC_RST_PMR 1'b0
`define GPFC_RST_FSEL 5'h00
`define GPFC_DRV_LOW 2'h0
`define GPFC_DRV_INVALID 2'h3

`endif

// ### verilog/gpfc_pfs_reg.v
// One pin's function select register: storage for its configuration fields.
// Assumes the caller gates the write strobe with the write guard.
`timescale 1ns/10ps
`include "gpfc_regs.vh"

module gpfc_pfs_reg
(
  input wire CLK_SYS,
  input wire NRST,
  input wire wr_en,
  input wire [31:0] wdata,
  output reg pu_en,
  output reg open_drain,
  output reg [1:0] drive,
  output reg irq_sel,
  output reg analog_sel,
  output reg periph_mode,
  output reg [4:0] func_sel
);

  always @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      pu_en <= `GPFC_RST_PULLUP;
      open_drain <= `GPFC_RST_OD;
      drive <= `GPFC_RST_DRV;
      irq_sel <= `GPFC_RST_IRQ_INPUT_SELECT;
      analog_sel <= `GPFC_RST_ANALOG_INPUT_SELECT;
      periph_mode <= `GPFC_RST_PMR;
      func_sel <= `GPFC_RST_FSEL;
    end
    else if (wr_en)
    begin
      // Duplicate function assignments across pins are stored as written.
      pu_en <= wdata[`GPFC_PFS_PULLUP_BIT];
      open_drain <= wdata[`GPFC_PFS_OD_BIT];
      drive <= wdata[`GPFC_PFS_DRV_MSB:`GPFC_PFS_DRV_LSB];
      irq_sel <= wdata[`GPFC_PFS_IRQ_INPUT_SELECT_BIT];
      analog_sel <= wdata[`GPFC_PFS_ANALOG_INPUT_SELECT_BIT];
      periph_mode <= wdata[`GPFC_PFS_PMR_BIT];
      func_sel <= wdata[`GPFC_PFS_FSEL_MSB:`GPFC_PFS_FSEL_LSB];
    end
  end

endmodule

// ### verilog/gpfc_pad_ctl.v
// Pad control for one pin: output mux, open-drain, pull-up and drive outputs.
// Assumes pin levels arrive synchronous to the system clock.
`timescale 1ns/10ps
`include "gpfc_regs.vh"

module gpfc_pad_ctl
(
  input wire CLK_SYS,
  input wire NRST,
  input wire latch,
  input wire dir,
  input wire pu_en,
  input wire open_drain,
  input wire [1:0] drive,
  input wire irq_sel,
  input wire analog_sel,
  input wire periph_mode,
  input wire periph_o,
  input wire periph_oe,
  input wire ebus,
  input wire pin_i,
  output reg pin_o,
  output reg pin_oe,
  output reg pin_pu,
  output reg [1:0] pin_drv,
  output reg pin_an,
  output reg pin_odm,
  output reg irq,
  output reg per_i
);

  wire drv_data;
  wire drv_en;

  assign drv_data = periph_mode ? periph_o : latch;
  assign drv_en = periph_mode ? periph_oe : dir;

  always @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      pin_o <= 1'b0;
      pin_oe <= 1'b0;
      pin_pu <= 1'b0;
      pin_drv <= `GPFC_DRV_LOW;
      pin_an <= 1'b0;
      pin_odm <= 1'b0;
      irq <= 1'b0;
      per_i <= 1'b0;
    end
    else
    begin
      // Open drain never drives high; a one releases the pin instead.
      pin_o <= open_drain ? 1'b0 : drv_data;
      pin_oe <= drv_en & ~(open_drain & drv_data);
      pin_pu <= pu_en & ~drv_en & ~ebus;
      // The invalid code falls back to low drive rather than an untested pad mode.
      pin_drv <= (drive == `GPFC_DRV_INVALID) ? `GPFC_DRV_LOW : drive;
      pin_an <= analog_sel;
      pin_odm <= open_drain;
      // IRQ and peripheral input paths are independent of each other.
      irq <= irq_sel & pin_i;
      per_i <= periph_mode & pin_i;
    end
  end

endmodule

// ### verilog/gpfc_top.v
// Top of the pin function block: APB register slave, port control registers,
// write guard and one function select register and pad controller per pin.
// Assumes an APB master on CLK_SYS and pad cells that resolve PIN_O/PIN_OE.
//
// Local design decisions: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
`include "gpfc_regs.vh"

module gpfc_top
#(
  parameter NPINS = 16
)
(
  input wire CLK_SYS,
  input wire NRST,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [11:0] PADDR,
  input wire [31:0] PWDATA,
  input wire [3:0] PSTRB,
  output reg [31:0] PRDATA,
  output wire PREADY,
  output wire PSLVERR,
  input wire [NPINS-1:0] PIN_I,
  output wire [NPINS-1:0] PIN_O,
  output wire [NPINS-1:0] PIN_OE,
  output wire [NPINS-1:0] PIN_PULLUP_EN,
  output wire [NPINS-1:0] PIN_OPEN_DRAIN,
  output wire [2*NPINS-1:0] PIN_DRIVE,
  output wire [NPINS-1:0] PIN_ANALOG_EN,
  output wire [5*NPINS-1:0] PERIPH_SEL,
  input wire [NPINS-1:0] PERIPH_O,
  input wire [NPINS-1:0] PERIPH_OE,
  output wire [NPINS-1:0] PERIPH_I,
  input wire [NPINS-1:0] EBUS_PIN,
  output wire [NPINS-1:0] IRQ_PIN
);

  // --------------------------------------------------------------------------
  // APB phase decode
  // --------------------------------------------------------------------------
  wire setup_phase;
  wire access_phase;
  wire wr_access;
  wire hit_one;
  wire hit_two;
  wire hit_guard;
  wire hit_pfs;
  wire [3:0] pfs_index;
  wire pfs_in_range;
  wire mapped;

  assign setup_phase = PSEL & ~PENABLE;
  assign access_phase = PSEL & PENABLE;
  assign wr_access = access_phase & PWRITE;

  assign hit_one = (PADDR == `GPFC_OFF_PORT_CTRL_ONE);
  assign hit_two = (PADDR == `GPFC_OFF_PORT_CTRL_TWO);
  assign hit_guard = (PADDR == `GPFC_OFF_WRITE_GUARD);
  assign pfs_index = PADDR[5:2];
  assign pfs_in_range = ({28'h0000000, pfs_index} < NPINS);
  assign hit_pfs = (PADDR >= `GPFC_OFF_PFS_BASE) && (PADDR <= `GPFC_OFF_PFS_LAST) &&
    (PADDR[1:0] == 2'h0) && pfs_in_range;
  assign mapped = hit_one | hit_two | hit_guard | hit_pfs;

  // Zero wait states: every access completes in its first access cycle.
  assign PREADY = 1'b1;

  // Writes to port_ctrl_two are errors because the register is read-only.
  assign PSLVERR = access_phase & (~mapped | (PWRITE & hit_two));

  // --------------------------------------------------------------------------
  // Port control one: direction and output latch
  // --------------------------------------------------------------------------
  reg [NPINS-1:0] dir;
  reg [NPINS-1:0] latch;
  localparam [31:0] p1_rst = `GPFC_RST_PORT_CTRL_ONE;
  wire [31:0] p1_mask;
  wire [31:0] p1_word;
  wire [31:0] p1_next;

  assign p1_mask = {{8{PSTRB[3]}}, {8{PSTRB[2]}}, {8{PSTRB[1]}}, {8{PSTRB[0]}}};
  assign p1_word = ({16'h0000, {(16-NPINS){1'b0}}, dir} << `GPFC_P1_DIR_LSB) |
    ({{(16-NPINS){1'b0}}, latch, 16'h0000});
  assign p1_next = (p1_word & ~p1_mask) | (PWDATA & p1_mask);

  always @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      dir <= p1_rst[`GPFC_P1_DIR_LSB +: NPINS];
      latch <= p1_rst[`GPFC_P1_LATCH_LSB +: NPINS];
    end
    else if (wr_access && hit_one)
    begin
      // Byte strobes let software load the latch half before the direction half.
      dir <= p1_next[`GPFC_P1_DIR_LSB +: NPINS];
      latch <= p1_next[`GPFC_P1_LATCH_LSB +: NPINS];
    end
  end

  // --------------------------------------------------------------------------
  // Write guard for the function select registers
  // --------------------------------------------------------------------------
  reg guard_en;

  always @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      guard_en <= `GPFC_RST_GUARD;
    end
    else if (wr_access && hit_guard && PSTRB[0])
    begin
      guard_en <= PWDATA[`GPFC_GUARD_EN_BIT];
    end
  end

  // --------------------------------------------------------------------------
  // Per-pin function select registers and pad controllers
  // --------------------------------------------------------------------------
  wire [NPINS-1:0] cfg_pullup;
  wire [NPINS-1:0] cfg_od;
  wire [2*NPINS-1:0] cfg_drive;
  wire [NPINS-1:0] cfg_irq_input_select;
  wire [NPINS-1:0] cfg_analog_input_select;
  wire [NPINS-1:0] cfg_pmr;
  wire [5*NPINS-1:0] cfg_fsel;
  wire [NPINS-1:0] pfs_wr;

  genvar gi;
  generate
    for (gi = 0; gi < NPINS; gi = gi + 1)
    begin : pin
      // Blocked writes complete normally on the bus but leave the register untouched.
      assign pfs_wr[gi] = wr_access & hit_pfs & (pfs_index == gi) & guard_en &
        (&PSTRB);

      gpfc_pfs_reg u_pfs
      (
        .CLK_SYS(CLK_SYS),
        .NRST(NRST),
        .wr_en(pfs_wr[gi]),
        .wdata(PWDATA),
        .pu_en(cfg_pullup[gi]),
        .open_drain(cfg_od[gi]),
        .drive(cfg_drive[2*gi +: 2]),
        .irq_sel(cfg_irq_input_select[gi]),
        .analog_sel(cfg_analog_input_select[gi]),
        .periph_mode(cfg_pmr[gi]),
        .func_sel(cfg_fsel[5*gi +: 5])
      );

      gpfc_pad_ctl u_pad
      (
        .CLK_SYS(CLK_SYS),
        .NRST(NRST),
        .latch(latch[gi]),
        .dir(dir[gi]),
        .pu_en(cfg_pullup[gi]),
        .open_drain(cfg_od[gi]),
        .drive(cfg_drive[2*gi +: 2]),
        .irq_sel(cfg_irq_input_select[gi]),
        .analog_sel(cfg_analog_input_select[gi]),
        .periph_mode(cfg_pmr[gi]),
        .periph_o(PERIPH_O[gi]),
        .periph_oe(PERIPH_OE[gi]),
        .ebus(EBUS_PIN[gi]),
        .pin_i(PIN_I[gi]),
        .pin_o(PIN_O[gi]),
        .pin_oe(PIN_OE[gi]),
        .pin_pu(PIN_PULLUP_EN[gi]),
        .pin_drv(PIN_DRIVE[2*gi +: 2]),
        .pin_an(PIN_ANALOG_EN[gi]),
        .pin_odm(PIN_OPEN_DRAIN[gi]),
        .irq(IRQ_PIN[gi]),
        .per_i(PERIPH_I[gi])
      );
    end
  endgenerate

  // The selector itself comes straight from the register flip-flops.
  assign PERIPH_SEL = cfg_fsel;

  // --------------------------------------------------------------------------
  // Read data, captured in the setup phase and held through the access phase
  // --------------------------------------------------------------------------
  reg [31:0] next_rdata;
  reg [31:0] pfs_word;
  integer k;

  always @*
  begin
    pfs_word = 32'h00000000;
    for (k = 0; k < NPINS; k = k + 1)
    begin
      if (pfs_index == k[3:0])
      begin
        pfs_word[`GPFC_PFS_LATCH_BIT] = latch[k];
        pfs_word[`GPFC_PFS_LEVEL_BIT] = PIN_I[k];
        pfs_word[`GPFC_PFS_DIR_BIT] = dir[k];
        pfs_word[`GPFC_PFS_PULLUP_BIT] = cfg_pullup[k];
        pfs_word[`GPFC_PFS_OD_BIT] = cfg_od[k];
        pfs_word[`GPFC_PFS_DRV_MSB:`GPFC_PFS_DRV_LSB] = cfg_drive[2*k +: 2];
        pfs_word[`GPFC_PFS_IRQ_INPUT_SELECT_BIT] = cfg_irq_input_select[k];
        pfs_word[`GPFC_PFS_ANALOG_INPUT_SELECT_BIT] = cfg_analog_input_select[k];
        pfs_word[`GPFC_PFS_PMR_BIT] = cfg_pmr[k];
        pfs_word[`GPFC_PFS_FSEL_MSB:`GPFC_PFS_FSEL_LSB] = cfg_fsel[5*k +: 5];
      end
    end
  end

  always @*
  begin
    next_rdata = 32'h00000000;
    if (hit_one)
    begin
      next_rdata = p1_word;
    end
    else if (hit_two)
    begin
      next_rdata = {{(32-NPINS){1'b0}}, PIN_I};
    end
    else if (hit_guard)
    begin
      next_rdata = {31'h00000000, guard_en};
    end
    else if (hit_pfs)
    begin
      next_rdata = pfs_word;
    end
  end

  always @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      PRDATA <= 32'h00000000;
    end
    else if (setup_phase && !PWRITE)
    begin
      PRDATA <= next_rdata;
    end
  end

endmodule

// ### sim/gpfc_top_props.sv
// Port assertions for the pin function block.
// Assumes it is bound into gpfc_top and that pin levels follow CLK_SYS.
`timescale 1ns/10ps

module gpfc_top_props
#(
  parameter NPINS = 16
)
(
  input wire CLK_SYS,
  input wire NRST,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [11:0] PADDR,
  input wire PSLVERR,
  input wire [NPINS-1:0] PIN_I,
  input wire [NPINS-1:0] PIN_O,
  input wire [NPINS-1:0] PIN_OE,
  input wire [NPINS-1:0] PIN_PULLUP_EN,
  input wire [NPINS-1:0] PIN_OPEN_DRAIN,
  input wire [2*NPINS-1:0] PIN_DRIVE,
  input wire [5*NPINS-1:0] PERIPH_SEL,
  input wire [NPINS-1:0] EBUS_PIN,
  input wire [NPINS-1:0] IRQ_PIN,
  input wire [NPINS-1:0] PERIPH_I
);
  wire acc = PSEL & PENABLE;
  logic wrote;
  logic guard_seen;
  logic bad_drv;

  // Sticky flags: conservative, any guard write opens the window.
  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      wrote <= 1'b0;
      guard_seen <= 1'b0;
    end
    else
    begin
      wrote <= wrote | (acc & PWRITE);
      guard_seen <= guard_seen | (acc & PWRITE & (PADDR == 12'h008));
    end
  end

  always_comb
  begin
    bad_drv = 1'b0;
    for (int i = 0; i < NPINS; i++)
      bad_drv = bad_drv | (PIN_DRIVE[2*i] & PIN_DRIVE[2*i+1]);
  end

  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);

  pins_at_reset_a: assert property (
    !wrote |-> PIN_OE == '0 && PIN_PULLUP_EN == '0 && PIN_DRIVE == '0)
    else $error("pad left reset state before any write");
  pfs_guarded_a: assert property (
    !guard_seen |-> PERIPH_SEL == '0 && PIN_OPEN_DRAIN == '0 && PERIPH_I == '0)
    else $error("function select changed while guarded");
  pullup_out_a: assert property ((PIN_PULLUP_EN & PIN_OE) == '0)
    else $error("pull-up on while driving");
  pullup_ebus_a: assert property ((PIN_PULLUP_EN & $past(EBUS_PIN)) == '0)
    else $error("pull-up on for bus pin");
  od_no_high_a: assert property ((PIN_OPEN_DRAIN & PIN_O) == '0)
    else $error("open drain drives high");
  drive_valid_a: assert property (!bad_drv)
    else $error("invalid drive code at pad");
  ro_write_err_a: assert property (acc && PWRITE && PADDR == 12'h004 |-> PSLVERR)
    else $error("write to input levels not refused");
  irq_from_pin_a: assert property ((IRQ_PIN & ~$past(PIN_I)) == '0)
    else $error("irq high with pin low");

  cover property (guard_seen && |PIN_PULLUP_EN);
  cover property (|(PIN_OE & PIN_OPEN_DRAIN));
  cover property (acc && PSLVERR);
endmodule

bind gpfc_top gpfc_top_props #(.NPINS(NPINS)) gpfc_top_props_inst (.CLK_SYS(CLK_SYS),
  .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
  .PSLVERR(PSLVERR), .PIN_I(PIN_I), .PIN_O(PIN_O), .PIN_OE(PIN_OE),
  .PIN_PULLUP_EN(PIN_PULLUP_EN), .PIN_OPEN_DRAIN(PIN_OPEN_DRAIN), .PIN_DRIVE(PIN_DRIVE),
  .PERIPH_SEL(PERIPH_SEL), .EBUS_PIN(EBUS_PIN), .IRQ_PIN(IRQ_PIN), .PERIPH_I(PERIPH_I));

// ### sim/gpfc_pin_model.sv
// Board around the package pins: resolves each pin's level.
// Assumes undriven pins without pull-up settle to ext_level.
`timescale 1ns/10ps

module gpfc_pin_model
#(
  parameter NPINS = 16
)
(
  input wire clk,
  input wire [NPINS-1:0] pin_o,
  input wire [NPINS-1:0] pin_oe,
  input wire [NPINS-1:0] pin_pu,
  input wire [NPINS-1:0] ext_level,
  output logic [NPINS-1:0] pin_i
);
  // Sampled once per clock so the block sees a synchronous level.
  initial pin_i = '0;
  always @(posedge clk)
    pin_i <= (pin_oe & pin_o) | (~pin_oe & (pin_pu | ext_level));
endmodule

// ### sim/tb_gpfc_top.sv
// Self-checking bench for the pin function block and its board model.
// Assumes zero-wait APB and a one-edge pad latency.
`timescale 1ns/10ps

module tb_gpfc_top;
  localparam NP = 16;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [NP-1:0] per_o = '0;
  logic [NP-1:0] per_oe = '0;
  logic [NP-1:0] ebus = '0;
  logic [NP-1:0] ext = 16'ha5a5;
  wire [31:0] prdata;
  wire pready;
  wire pslverr;
  wire [NP-1:0] pin_i, pin_o, pin_oe, pin_pu, pin_od, pin_an, per_i, irq;
  wire [2*NP-1:0] pin_drv;
  wire [5*NP-1:0] per_sel;
  logic [31:0] rd;
  logic err;
  int errors = 0;
  int cmp_count = 0;

  gpfc_top #(.NPINS(NP)) gpfc_top_inst (.CLK_SYS(clk), .NRST(nrst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(4'hf),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .PIN_I(pin_i), .PIN_O(pin_o),
    .PIN_OE(pin_oe), .PIN_PULLUP_EN(pin_pu), .PIN_OPEN_DRAIN(pin_od), .PIN_DRIVE(pin_drv),
    .PIN_ANALOG_EN(pin_an), .PERIPH_SEL(per_sel), .PERIPH_O(per_o), .PERIPH_OE(per_oe),
    .PERIPH_I(per_i), .EBUS_PIN(ebus), .IRQ_PIN(irq));
  gpfc_pin_model #(.NPINS(NP)) gpfc_pin_model_inst (.clk(clk), .pin_o(pin_o),
    .pin_oe(pin_oe), .pin_pu(pin_pu), .ext_level(ext), .pin_i(pin_i));

  initial forever #5 clk = ~clk;

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [11:0] addr, input logic [31:0] exp, input string name);
    apb(1'b0, addr, '0);
    chk(name, exp, rd);
  endtask

  task automatic settle;
    repeat (4) @(posedge clk);
    #1;
  endtask

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // A full run needs about 110 cycles; this leaves a wide margin.
  initial
  begin
    #100000;
    errors++;
    final_report();
  end

  initial
  begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    settle();
    chk("oe reset", '0, pin_oe);
    chk("pull-up reset", '0, pin_pu);
    chk("drive reset", '0, pin_drv);
    rd_chk(12'h000, 32'h0, "port ctrl one reset");
    rd_chk(12'h070, 32'h0, "pfs12 reset");
    rd_chk(12'h004, {16'h0, ext}, "pin levels");
    apb(1'b1, 12'h004, 32'hffff);
    chk("ro write error", 1, err);
    rd_chk(12'h004, {16'h0, ext}, "levels kept");
    apb(1'b1, 12'h000, 32'h0f0f0000);
    apb(1'b1, 12'h000, 32'h0f0f00ff);
    settle();
    chk("oe", 32'h00ff, pin_oe);
    chk("out", 32'h000f, pin_o & pin_oe);
    rd_chk(12'h000, 32'h0f0f00ff, "latch readback");
    rd_chk(12'h004, 32'ha50f, "driven levels");
    apb(1'b1, 12'h070, 32'h10);
    rd_chk(12'h070, 32'h0, "guarded write");
    apb(1'b1, 12'h008, 32'h1);
    apb(1'b1, 12'h070, 32'h1f004c50);
    apb(1'b1, 12'h070, 32'h1f014c50);
    apb(1'b1, 12'h074, 32'h1f000400);
    apb(1'b1, 12'h040, 32'h00000010);
    settle();
    rd_chk(12'h070, 32'h1f014c52, "pfs12 fields");
    chk("pull-up on", 1, pin_pu[12]);
    chk("invalid drive", 0, pin_drv[25:24]);
    chk("function sel", 5'h1f, per_sel[64:60]);
    chk("dup function", 5'h1f, per_sel[69:65]);
    chk("middle drive", 2'b01, pin_drv[27:26]);
    chk("gpio out pull-up", 0, pin_pu[0]);
    rd_chk(12'h040, 32'h17, "pfs0 mirror");
    chk("irq and periph", 2'b11, {irq[12], per_i[12]});
    rd_chk(12'h074, 32'h1f000402, "pfs13 own");
    @(posedge clk);
    per_oe[12] <= 1'b1;
    settle();
    chk("od drive low", 4'b1010, {pin_od[12], pin_pu[12], pin_oe[12], pin_o[12]});
    @(posedge clk);
    per_oe[12] <= 1'b0;
    ebus[12] <= 1'b1;
    settle();
    chk("bus pin pull-up", 0, pin_pu[12]);
    @(posedge clk);
    ebus[12] <= 1'b0;
    apb(1'b1, 12'h070, 32'h1f004c50);
    apb(1'b1, 12'h070, 32'h00008000);
    apb(1'b1, 12'h008, 32'h0);
    apb(1'b1, 12'h070, 32'h0);
    settle();
    chk("analog on", 1, pin_an[12]);
    rd_chk(12'h070, 32'h8000, "guard closed");
    rd_chk(12'h0c0, 32'h0, "unmapped read");
    chk("unmapped error", 1, err);
    final_report();
  end
endmodule
